// ---- ipc_pin_mux.sv ----
// port g analog select, change notifier and remappable pin fabric
// Operation
// - port g analog bits 9-6 set analog mode and block the digital port read.
// - port g unimplemented analog select bits ignore writes and read zero.
// - implemented analog select bits come out of reset as one.
// - an enabled pin changing level raises the change interrupt.
// - change detection has a clock independent path for sleep.
// - the change notifier watches 84 inputs.
// - each change input has its own interrupt enable bit.
// - each change input has separate weak pull-up and pull-down enables.
// - 44 remappable pins; 0-31 in and out, 32-43 input only.
// - inputs and outputs of remappable peripherals map independently to any pin.
// - a lock guards the mapping against spurious changes.
// - remappable peripherals reach no pin until software maps them.
// - fixed pin peripherals other than the parallel port always own their default pin when active.
// - remapped outputs override port output and parallel master port output.
// - specialized outputs such as usb override remapped outputs.
// - remapped inputs never control a pin output buffer.
// - remapped inputs see the pin only in digital mode.
// - no remapping for two-wire, change inputs, calendar alarm, parallel port, analog.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ipc_cfg.svh"

module ipc_pin_mux (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire ipc_pkg::ipc_wb_req_t   wb_req,
    output logic [31:0]                 wb_rdata,
    output logic                        wb_ack,
    input  wire logic [15:0]            portg_pin,
    output logic [15:0]                 portg_analog,
    input  wire logic [`IPC_N_CHG-1:0]  change_pin,
    output logic [`IPC_N_CHG-1:0]       change_pullup,
    output logic [`IPC_N_CHG-1:0]       change_pulldown,
    output logic                        change_irq,
    output logic                        change_wake,
    input  wire logic [`IPC_N_RP-1:0]   remap_pin,
    input  wire logic [`IPC_N_RP-1:0]   remap_pin_analog,
    input  wire logic [`IPC_N_RPIO-1:0] pin_direction,
    input  wire logic [`IPC_N_RPIO-1:0] port_out,
    input  wire logic [`IPC_N_RPIO-1:0] parallel_out,
    input  wire logic [`IPC_N_RPIO-1:0] parallel_oe,
    input  wire logic [`IPC_N_RPIO-1:0] special_out,
    input  wire logic [`IPC_N_RPIO-1:0] special_oe,
    input  wire logic [`IPC_N_PIN_OUT-1:0] periph_out,
    output logic [`IPC_N_PIN_IN-1:0]    periph_in,
    output logic [`IPC_N_RPIO-1:0]      remap_out,
    output logic [`IPC_N_RPIO-1:0]      remap_oe
);

    // byte lane merge of a bus write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // level of the pin a peripheral input is mapped to; analog or unmapped reads zero
    function automatic logic pick_pin(input logic [`IPC_N_RP-1:0] lvl, input logic [`IPC_N_RP-1:0] ana,
                                      input logic [5:0] idx);
        logic res;
        res = 1'b0;
        for (int p = 0; p < `IPC_N_RP; p++) begin
            if (idx == 6'(p)) begin
                res = lvl[p] & ~ana[p];
            end
        end
        return res;
    endfunction

    logic [15:0]                 ana_sel_q;
    logic [95:0]                 chg_en_q;
    logic [95:0]                 chg_pu_q;
    logic [95:0]                 chg_pd_q;
    logic [`IPC_N_CHG-1:0]       chg_ref_q;
    logic                        chg_flag_q;
    logic                        chg_flag_d;
    ipc_pkg::ipc_lock_t          lock_q;
    ipc_pkg::ipc_lock_t          lock_d;
    logic [5:0]                  in_map_q [`IPC_N_PIN_IN];
    logic [5:0]                  out_map_q [`IPC_N_RPIO];
    logic [63:0]                 in_rd;
    logic [255:0]                out_rd;
    logic [31:0]                 rd_d;
    logic                        ack_q;
    logic [`IPC_N_PIN_IN-1:0]    pin_in_d;
    logic [`IPC_N_RPIO-1:0]      out_d;
    logic [`IPC_N_RPIO-1:0]      oe_d;

    // bus decode: one access per request, answered one edge later
    wire        acc      = wb_req.cyc & wb_req.stb & ~ack_q;
    wire        wr       = acc & wb_req.we;
    wire [7:0]  adr      = wb_req.adr;
    wire        locked   = (lock_q != ipc_pkg::ipc_st_open);
    wire        stat_clr = wr & (adr == `IPC_A_CNSTAT) & wb_req.sel[0] & wb_req.dat[0];
    wire        lock_wr  = wr & (adr == `IPC_A_LOCK) & wb_req.sel[0];
    // change inputs come straight from their pins, never through the remap fabric
    wire [`IPC_N_CHG-1:0] chg_hit = chg_en_q[`IPC_N_CHG-1:0] & (change_pin ^ chg_ref_q);
    // write data merged into the stored analog half word
    wire [31:0] ana_merged = lane_merge({16'h0, ana_sel_q}, wb_req.dat, wb_req.sel);
    wire [95:0] chg_mask   = `IPC_CHG_MASK; // 84 real inputs, the rest of the words read zero

    // analog select: only bits 9-6 are stored, so the rest read zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ana_sel_q <= `IPC_ANS_RST;
        end else if (wr && adr == `IPC_A_ANALOG) begin
            ana_sel_q <= ana_merged[15:0] & `IPC_ANS_MASK;
        end
    end

    // change enables and weak pulls, three words each
    for (genvar w = 0; w < 3; w++) begin : g_chg_word
        always_ff @(posedge core_clk) begin
            if (srst) begin
                chg_en_q[32*w +: 32] <= 32'h0;
                chg_pu_q[32*w +: 32] <= 32'h0;
                chg_pd_q[32*w +: 32] <= 32'h0;
            end else if (wr) begin
                if (adr == 8'(`IPC_A_CNEN + 4*w)) begin
                    chg_en_q[32*w +: 32] <= lane_merge(chg_en_q[32*w +: 32], wb_req.dat, wb_req.sel)
                                            & chg_mask[32*w +: 32];
                end
                if (adr == 8'(`IPC_A_CNPU + 4*w)) begin
                    chg_pu_q[32*w +: 32] <= lane_merge(chg_pu_q[32*w +: 32], wb_req.dat, wb_req.sel)
                                            & chg_mask[32*w +: 32];
                end
                if (adr == 8'(`IPC_A_CNPD + 4*w)) begin
                    chg_pd_q[32*w +: 32] <= lane_merge(chg_pd_q[32*w +: 32], wb_req.dat, wb_req.sel)
                                            & chg_mask[32*w +: 32];
                end
            end
        end
    end

    // change flag: a new change beats a clear in the same cycle
    assign chg_flag_d = (|chg_hit) | (chg_flag_q & ~stat_clr);

    // reference levels follow the pins; with the clock stopped they hold the last level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            chg_ref_q  <= '0;
            chg_flag_q <= 1'b0;
        end else begin
            chg_ref_q  <= change_pin;
            chg_flag_q <= chg_flag_d;
        end
    end

    // clockless wake: compares pins against the frozen reference, so it works in sleep
    assign change_wake = |chg_hit;

    // mapping lock, two key writes in a row reopen it
    always_comb begin
        lock_d = lock_q;
        if (lock_wr) begin
            case (lock_q)
                ipc_pkg::ipc_st_open: begin
                    if (wb_req.dat[0]) begin
                        lock_d = ipc_pkg::ipc_st_locked;
                    end
                end
                ipc_pkg::ipc_st_locked: begin
                    if (wb_req.dat[7:0] == `IPC_KEY_ONE) begin
                        lock_d = ipc_pkg::ipc_st_keyed;
                    end
                end
                ipc_pkg::ipc_st_keyed: begin
                    lock_d = (wb_req.dat[7:0] == `IPC_KEY_TWO) ? ipc_pkg::ipc_st_open
                                                               : ipc_pkg::ipc_st_locked;
                end
                default: begin
                    lock_d = ipc_pkg::ipc_st_locked;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            lock_q <= ipc_pkg::ipc_st_open;
        end else begin
            lock_q <= lock_d;
        end
    end

    // input map: one byte lane per peripheral input, none selected after reset
    for (genvar i = 0; i < `IPC_N_PIN_IN; i++) begin : g_in_map
        always_ff @(posedge core_clk) begin
            if (srst) begin
                in_map_q[i] <= `IPC_IN_NONE;
            end else if (wr && !locked && adr == 8'(`IPC_A_INMAP + 4*(i/4)) && wb_req.sel[i%4]) begin
                in_map_q[i] <= wb_req.dat[8*(i%4) +: 6];
            end
        end
        assign in_rd[8*i +: 8] = {2'b00, in_map_q[i]};
        // only pins 0-43 exist; codes above select nothing
        assign pin_in_d[i] = pick_pin(remap_pin, remap_pin_analog, in_map_q[i]);
    end

    // output map: one byte lane per pin 0-31, null after reset
    for (genvar p = 0; p < `IPC_N_RPIO; p++) begin : g_out_map
        wire [5:0] code      = out_map_q[p];
        wire       remap_act = (code != `IPC_OUT_NULL) && (code <= 6'(`IPC_N_PIN_OUT));
        wire       remap_val = remap_act ? periph_out[3'(code - 6'h01)] : 1'b0;
        always_ff @(posedge core_clk) begin
            if (srst) begin
                out_map_q[p] <= `IPC_OUT_NULL;
            end else if (wr && !locked && adr == 8'(`IPC_A_OUTMAP + 4*(p/4)) && wb_req.sel[p%4]) begin
                out_map_q[p] <= wb_req.dat[8*(p%4) +: 6];
            end
        end
        assign out_rd[8*p +: 8] = {2'b00, out_map_q[p]};
        // special function first, then remapped output, then parallel port, then port latch
        assign out_d[p] = special_oe[p] ? special_out[p] :
                          remap_act     ? remap_val      :
                          parallel_oe[p] ? parallel_out[p] : port_out[p];
        // buffer enable never comes from a remapped input
        assign oe_d[p] = special_oe[p] | parallel_oe[p] | ~pin_direction[p];
    end

    // register read selection
    always_comb begin
        rd_d = 32'h0;
        if (adr == `IPC_A_ANALOG) begin
            rd_d = {16'h0, ana_sel_q};
        end else if (adr == `IPC_A_PORTG) begin
            rd_d = {16'h0, portg_pin & ~ana_sel_q};
        end else if (adr == `IPC_A_CNSTAT) begin
            rd_d = {31'h0, chg_flag_q};
        end else if (adr == `IPC_A_LOCK) begin
            rd_d = {30'h0, lock_q};
        end
        for (int w = 0; w < 3; w++) begin
            if (adr == 8'(`IPC_A_CNEN + 4*w)) begin
                rd_d = chg_en_q[32*w +: 32];
            end
            if (adr == 8'(`IPC_A_CNPU + 4*w)) begin
                rd_d = chg_pu_q[32*w +: 32];
            end
            if (adr == 8'(`IPC_A_CNPD + 4*w)) begin
                rd_d = chg_pd_q[32*w +: 32];
            end
        end
        for (int w = 0; w < 2; w++) begin
            if (adr == 8'(`IPC_A_INMAP + 4*w)) begin
                rd_d = in_rd[32*w +: 32];
            end
        end
        for (int w = 0; w < 8; w++) begin
            if (adr == 8'(`IPC_A_OUTMAP + 4*w)) begin
                rd_d = out_rd[32*w +: 32];
            end
        end
    end

    // output flops; every output except change_wake comes from here or from a stored register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_q     <= 1'b0;
            wb_rdata  <= 32'h0;
            periph_in <= '0;
            remap_out <= '0;
            remap_oe  <= '0;
        end else begin
            ack_q     <= acc;
            wb_rdata  <= acc ? rd_d : 32'h0;
            periph_in <= pin_in_d;
            remap_out <= out_d;
            remap_oe  <= oe_d;
        end
    end

    assign wb_ack          = ack_q;
    assign portg_analog    = ana_sel_q;
    assign change_pullup   = chg_pu_q[`IPC_N_CHG-1:0];
    assign change_pulldown = chg_pd_q[`IPC_N_CHG-1:0];
    assign change_irq      = chg_flag_q;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_rd(logic [7:0] a);
        acc && !wb_req.we && adr == a;
    endsequence

    chk_analog_reserved_zero: assert property (s_rd(`IPC_A_ANALOG) |=> wb_ack && (wb_rdata & 32'hfffffc3f) == 32'h0)
        else $error("reserved analog select bits read nonzero");
    chk_analog_reset_one: assert property ($past(srst) |-> ana_sel_q == `IPC_ANS_RST)
        else $error("analog select not all ones after reset");
    chk_portg_read_block: assert property (s_rd(`IPC_A_PORTG)
        |=> wb_rdata[15:0] == ($past(portg_pin) & ~$past(ana_sel_q)))
        else $error("analog pin visible in port read");
    chk_change_raises_irq: assert property (|chg_hit |=> change_irq)
        else $error("enabled change did not raise irq");
    chk_wake_then_flag: assert property (change_wake && !stat_clr ##1 stat_clr |-> change_irq)
        else $error("wake seen but flag lost");
    chk_lock_blocks_map: assert property (locked && wr |=> $stable(out_rd) && $stable(in_rd))
        else $error("mapping changed while locked");
    chk_special_wins_pin: assert property (##1 (remap_out & $past(special_oe)) == ($past(special_out)
        & $past(special_oe)))
        else $error("special output did not win");
    chk_no_default_pin: assert property ($past(srst) ##1 !wr[*2] |-> periph_in == '0)
        else $error("unmapped peripheral input not zero");
    chk_oe_from_dir: assert property (##1 remap_oe == ($past(special_oe) | $past(parallel_oe)
        | ~$past(pin_direction)))
        else $error("output enable not from direction or fixed function");
    chk_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    // flag stickiness, register masking, map register reset and the map fabric seen from the outputs
    chk_irq_holds: assert property (change_irq && !stat_clr |=> change_irq)
        else $error("change flag dropped without a clear");
    chk_disabled_quiet: assert property (!change_irq && chg_en_q == 96'h0 |=> !change_irq)
        else $error("change flag set with every enable off");
    chk_analog_wr_mask: assert property (wr && adr == `IPC_A_ANALOG |=> (portg_analog & 16'hfc3f) == 16'h0)
        else $error("unimplemented analog select bit took a write");
    chk_maps_reset: assert property ($past(srst)
        |-> out_map_q[0] == `IPC_OUT_NULL && in_map_q[0] == `IPC_IN_NONE)
        else $error("pin map not cleared by reset");
    chk_analog_in_zero: assert property (in_map_q[0] < 6'd44 && remap_pin_analog[in_map_q[0]]
        |=> !periph_in[0])
        else $error("analog pin reached a remapped input");
    chk_map_range: assert property (in_map_q[1] > 6'd43 |=> !periph_in[1])
        else $error("input mapped past the last pin saw a level");
    chk_remap_over_port: assert property (out_map_q[0] == 6'h03 && !special_oe[0]
        |=> remap_out[0] == $past(periph_out[2]))
        else $error("remapped output lost to port or parallel output");

endmodule

// ---- ipc_cfg.svh ----
// address map, field layouts, reset values and keys of the pin select block
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_N_CHG      84
`define IPC_N_RP       44
`define IPC_N_RPIO     32
`define IPC_N_PIN_IN   8
`define IPC_N_PIN_OUT  8
`define IPC_A_ANALOG   8'h00
`define IPC_A_PORTG    8'h04
`define IPC_A_CNEN     8'h08
`define IPC_A_CNPU     8'h14
`define IPC_A_CNPD     8'h20
`define IPC_A_CNSTAT   8'h2c
`define IPC_A_LOCK     8'h30
`define IPC_A_INMAP    8'h34
`define IPC_A_OUTMAP   8'h40
`define IPC_ANS_MASK   16'h03c0
`define IPC_ANS_RST    16'h03c0
`define IPC_CHG_MASK   96'h000fffffffffffffffffffff
`define IPC_IN_NONE    6'h3f
`define IPC_OUT_NULL   6'h00
`define IPC_KEY_ONE    8'h46
`define IPC_KEY_TWO    8'h57
`endif

// ---- ipc_pkg.sv ----
// types shared by the pin select block
package ipc_pkg;
    // classic wishbone request, driven by the bus master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ipc_wb_req_t;

    // mapping lock along open -> locked -> keyed -> open; one bit flips per step except keyed -> open
    typedef enum logic [1:0] {
        ipc_st_open   = 2'b00,
        ipc_st_locked = 2'b01,
        ipc_st_keyed  = 2'b11
    } ipc_lock_t;
endpackage

// ---- ipc_far_model.sv ----
// far side model: change notice pins with weak pull resolution
`timescale 1ns/1ps
`include "ipc_cfg.svh"

module ipc_far_model (
    input  wire logic [`IPC_N_CHG-1:0] drive_en,
    input  wire logic [`IPC_N_CHG-1:0] drive_val,
    input  wire logic [`IPC_N_CHG-1:0] pull_up_en,
    input  wire logic [`IPC_N_CHG-1:0] pull_down_en,
    input  wire logic                  core_clk,
    output logic [`IPC_N_CHG-1:0]      change_pin
);
    logic [`IPC_N_CHG-1:0] last_q;

    // released lines follow the weak pulls; unpulled ones flip so stale levels never pass
    always_comb begin
        for (int i = 0; i < `IPC_N_CHG; i++) begin
            if (drive_en[i]) begin
                change_pin[i] = drive_val[i];
            end else if (pull_up_en[i]) begin
                change_pin[i] = 1'b1;
            end else if (pull_down_en[i]) begin
                change_pin[i] = 1'b0;
            end else begin
                change_pin[i] = ~last_q[i];
            end
        end
    end

    // last level seen, only used to make floating pins wander
    always_ff @(posedge core_clk) begin
        last_q <= change_pin;
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the pin select block
`timescale 1ns/1ps
`include "ipc_cfg.svh"

module testbench;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    ipc_pkg::ipc_wb_req_t req = '0;
    logic [31:0] wb_rdata;
    logic wb_ack, change_irq, change_wake;
    logic [15:0] portg_pin = '0;
    logic [15:0] portg_analog;
    logic [83:0] change_pin, change_pullup, change_pulldown;
    logic [83:0] drv_en = '1;
    logic [83:0] drv_val = '0;
    logic [43:0] remap_pin = '0;
    logic [43:0] remap_pin_analog = '0;
    logic [31:0] pin_direction = '1;
    logic [31:0] port_out = '0;
    logic [31:0] parallel_out = '0;
    logic [31:0] parallel_oe = '0;
    logic [31:0] special_out = '0;
    logic [31:0] special_oe = '0;
    logic [7:0] periph_out = '0;
    logic [7:0] periph_in;
    logic [31:0] remap_out, remap_oe;
    logic [31:0] seed = 32'hd1cf2356;
    logic [31:0] q, r;
    int error_cnt = 0;
    int n_tests = 0;

    always #10 core_clk = ~core_clk;

    ipc_pin_mux ipc_pin_mux_inst (.core_clk(core_clk), .srst(srst), .wb_req(req), .wb_rdata(wb_rdata),
        .wb_ack(wb_ack), .portg_pin(portg_pin), .portg_analog(portg_analog), .change_pin(change_pin),
        .change_pullup(change_pullup), .change_pulldown(change_pulldown), .change_irq(change_irq),
        .change_wake(change_wake), .remap_pin(remap_pin), .remap_pin_analog(remap_pin_analog),
        .pin_direction(pin_direction), .port_out(port_out), .parallel_out(parallel_out),
        .parallel_oe(parallel_oe), .special_out(special_out), .special_oe(special_oe),
        .periph_out(periph_out), .periph_in(periph_in), .remap_out(remap_out), .remap_oe(remap_oe));

    ipc_far_model ipc_far_model_inst (.drive_en(drv_en), .drive_val(drv_val), .pull_up_en(change_pullup),
        .pull_down_en(change_pulldown), .core_clk(core_clk), .change_pin(change_pin));

    // lfsr stepped on every draw
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // expected {oe1, oe0, out1, out0}: pin 0 carries function 3, pin 1 an out-of-range code
    function automatic logic [3:0] exp_fab();
        logic o0, o1;
        o0 = special_oe[0] ? special_out[0] : periph_out[2];
        o1 = special_oe[1] ? special_out[1] : (parallel_oe[1] ? parallel_out[1] : port_out[1]);
        return {special_oe[1:0] | parallel_oe[1:0] | ~pin_direction[1:0], o1, o0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; waits for ack with a bound, never a fixed latency
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rq = wb_rdata;
        if (n >= 20) chk(32'h1, 32'h0);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask

    task automatic summarize();
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(20 * 4000);
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1 chk({16'h0, portg_analog}, 32'h03c0);
        chk({23'h0, periph_in, remap_oe[0]}, 32'h0);
        rd(`IPC_A_ANALOG, 32'h03c0);
        wb(1'b1, `IPC_A_ANALOG, 32'hfffffc3f, q);
        rd(`IPC_A_ANALOG, 32'h0);
        r = rnd();
        portg_pin <= r[15:0];
        rd(`IPC_A_PORTG, {16'h0, r[15:0]});
        wb(1'b1, `IPC_A_ANALOG, 32'h0240, q);
        chk({16'h0, portg_analog}, 32'h0240);
        rd(`IPC_A_PORTG, {16'h0, portg_pin & 16'hfdbf});
        rd(8'hfc, 32'h0);
        // weak pulls only on pins kept as inputs
        r = rnd() & pin_direction;
        wb(1'b1, `IPC_A_CNPU, r, q);
        chk(change_pullup[31:0], r);
        wb(1'b1, `IPC_A_CNPD, ~r, q);
        chk(change_pulldown[31:0], ~r);
        wb(1'b1, 8'h1c, 32'hffffffff, q);
        rd(8'h1c, 32'h000fffff);
        // change notice on a random enabled input, then a disabled one; usb data inputs 82-83 stay still
        for (int t = 0; t < 6; t++) begin
            r = rnd() & 32'h1f;
            wb(1'b1, `IPC_A_CNEN, 32'h1 << r, q);
            @(posedge core_clk);
            drv_val[r] <= ~drv_val[r];
            #1 chk({31'h0, change_wake}, 32'h1);
            @(posedge core_clk);
            #1 chk({31'h0, change_irq}, 32'h1);
            wb(1'b1, `IPC_A_CNSTAT, 32'h1, q);
            rd(`IPC_A_CNSTAT, 32'h0);
            drv_val[r ^ 32'h1] <= ~drv_val[r ^ 32'h1];
            repeat (2) @(posedge core_clk);
            #1 chk({31'h0, change_irq}, 32'h0);
        end
        // input 0 from input-only pin 35, input 1 out of range; pin 0 function 3, pin 1 code 9
        wb(1'b1, `IPC_A_INMAP, 32'h3f3f2c23, q);
        wb(1'b1, `IPC_A_OUTMAP, 32'h00000903, q);
        rd(`IPC_A_INMAP, 32'h3f3f2c23);
        for (int t = 0; t < 24; t++) begin
            @(posedge core_clk);
            q = rnd();
            r = rnd();
            remap_pin <= {q[11:0], r};
            remap_pin_analog <= {8'h0, q[31], 3'h0, rnd()};
            {pin_direction, port_out} <= {rnd(), rnd()};
            {parallel_out, parallel_oe} <= {rnd(), rnd()};
            {special_out, special_oe} <= {rnd(), rnd() & {32{t[0]}}};
            r = rnd();
            periph_out <= r[7:0];
            @(posedge core_clk);
            #1 chk({remap_oe[1:0], remap_out[1:0]}, exp_fab());
            chk(periph_in[1:0], {1'b0, remap_pin[35] & ~remap_pin_analog[35]});
        end
        // lock, refused map write, two-key open
        wb(1'b1, `IPC_A_LOCK, 32'h1, q);
        rd(`IPC_A_LOCK, 32'h1);
        wb(1'b1, `IPC_A_INMAP, 32'h01010101, q);
        rd(`IPC_A_INMAP, 32'h3f3f2c23);
        wb(1'b1, `IPC_A_LOCK, 32'h46, q);
        wb(1'b1, `IPC_A_LOCK, 32'h57, q);
        rd(`IPC_A_LOCK, 32'h0);
        summarize();
    end
endmodule
